// [include/sram_ctl_pkg.sv]
/*
  Shared constants and types for the burst SRAM cycle control block:
  widths, burst counter constants, reset values and the cycle encoding.
  Assumes a single 200 MHz system clock and no register bus.
*/
package sram_ctl_pkg;
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = ADDR_W + LANES + DATA_W;
  // Burst offset counter constants and lane masks
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  // Values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  // Cycles from a sampled read to data standing on the pins
  localparam int RD_LAT_CYC = 2;
  typedef enum logic [1:0] {
    cyc_desel,
    cyc_begin,
    cyc_cont,
    cyc_susp
  } cycle_e;
endpackage

// [hw/sram_wr_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides, parameterised width and
  depth. Holds write requests on their way to the storage array.
  Assumes one clock and an active-low asynchronous reset.
*/
module sram_wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = DEPTH[PTR_W:0];

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign o_ready = (count_reg != DEPTH_CNT);
  assign o_valid = (count_reg != '0);
  assign o_data = mem_reg[rd_ptr_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Storage needs no reset; only the pointers and the count carry state
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// [hw/sram_cycle_ctl.sv]
/*
  Cycle decoder and burst control of a pipelined burst SRAM. Samples the
  selects, strobes, advance and write inputs each rising edge, drives the
  storage array ports and the data pins.
  Assumes the bus master runs on i_clk_sys, so its inputs need no
  synchroniser; the output enable pin acts without the clock.
*/
module sram_cycle_ctl (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_chip_sel_low_a,
  input wire logic i_chip_sel_high,
  input wire logic i_chip_sel_low_b,
  input wire logic i_proc_addr_load_n,
  input wire logic i_ctrl_addr_load_n,
  input wire logic i_burst_advance_n,
  input wire logic i_all_bytes_write_n,
  input wire logic i_byte_write_gate_n,
  input wire logic i_lane0_write_n,
  input wire logic i_lane1_write_n,
  input wire logic i_lane2_write_n,
  input wire logic i_lane3_write_n,
  input wire logic i_linear_order_sel_n,
  input wire logic i_out_en_n,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] i_dq,
  output logic [sram_ctl_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe_n,
  output logic o_arr_rd_en,
  output logic [sram_ctl_pkg::ADDR_W-1:0] o_arr_rd_addr,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] i_arr_rd_data,
  output logic o_arr_wr_valid,
  input wire logic i_arr_wr_ready,
  output logic [sram_ctl_pkg::ADDR_W-1:0] o_arr_wr_addr,
  output logic [sram_ctl_pkg::LANES-1:0] o_arr_wr_lanes,
  output logic [sram_ctl_pkg::DATA_W-1:0] o_arr_wr_data,
  output logic o_wr_ready
);
  import sram_ctl_pkg::*;

  cycle_e cyc;
  logic chip_en;
  logic wr_qual;
  logic is_rd;
  logic is_wr;
  logic [LANES-1:0] lanes;
  logic [ADDR_W-1:0] eff_addr;
  logic [BURST_W-1:0] cur_off;
  logic [BURST_W-1:0] cnt_next;
  logic [ADDR_W-BURST_W-1:0] base_reg;
  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] cnt_reg;
  logic rd_en_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic drive_reg;
  logic [DATA_W-1:0] dq_reg;
  logic [FIFO_W-1:0] fifo_out;

  // Offset of a beat: sum for linear order, XOR for interleaved
  function automatic logic [BURST_W-1:0] beat_off(input logic lin,
                                                  input logic [BURST_W-1:0] s,
                                                  input logic [BURST_W-1:0] c);
    beat_off = lin ? BURST_W'(s + c) : (s ^ c);
  endfunction

  assign chip_en = i_chip_sel_high && !i_chip_sel_low_a && !i_chip_sel_low_b;

  // Write qualifier and lane mask; global write overrides the lane inputs
  always_comb begin
    if (!i_all_bytes_write_n) begin
      lanes = LANES_ALL;
    end else if (!i_byte_write_gate_n) begin
      lanes = ~{i_lane3_write_n, i_lane2_write_n, i_lane1_write_n, i_lane0_write_n};
    end else begin
      lanes = LANES_NONE;
    end
  end
  assign wr_qual = (lanes != LANES_NONE);

  // Cycle decode; processor strobe counts only with first select low
  always_comb begin
    is_wr = 1'b0;
    if (!i_chip_sel_low_a && !i_proc_addr_load_n) begin
      cyc = chip_en ? cyc_begin : cyc_desel;
    end else if (!i_ctrl_addr_load_n) begin
      cyc = chip_en ? cyc_begin : cyc_desel;
      is_wr = chip_en && wr_qual;
    end else begin
      cyc = i_burst_advance_n ? cyc_susp : cyc_cont;
      is_wr = wr_qual;
    end
  end
  assign is_rd = (cyc != cyc_desel) && !is_wr;

  // Next counter value; only a strobe or an accepted advance moves it
  always_comb begin
    case (cyc)
      cyc_begin: cnt_next = BURST_FIRST;
      cyc_cont: cnt_next = cnt_reg + BURST_STEP;
      cyc_susp: cnt_next = cnt_reg;
      cyc_desel: cnt_next = cnt_reg;
      default: cnt_next = cnt_reg;
    endcase
  end

  // Address used by this cycle: external on a begin, internal otherwise
  assign cur_off = beat_off(i_linear_order_sel_n == 1'b0, start_reg, cnt_next);
  assign eff_addr = (cyc == cyc_begin) ? i_addr : {base_reg, cur_off};

  // Burst address state, sampled on the rising edge only
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_reg <= ADDR_RST[ADDR_W-1:BURST_W];
      start_reg <= BURST_FIRST;
      cnt_reg <= BURST_FIRST;
    end else begin
      if (cyc == cyc_begin) begin
        base_reg <= i_addr[ADDR_W-1:BURST_W];
        start_reg <= i_addr[BURST_W-1:0];
      end
      cnt_reg <= cnt_next;
    end
  end

  // Read issue stage; dummy reads issue too so the counter story matches
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_en_reg <= 1'b0;
      rd_addr_reg <= ADDR_RST;
    end else begin
      rd_en_reg <= is_rd;
      if (is_rd) begin
        rd_addr_reg <= eff_addr;
      end
    end
  end
  assign o_arr_rd_en = rd_en_reg;
  assign o_arr_rd_addr = rd_addr_reg;

  // Output stage; a deselect or write leaves the drive schedule clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_reg <= 1'b0;
      dq_reg <= DATA_RST;
    end else begin
      drive_reg <= rd_en_reg;
      if (rd_en_reg) begin
        dq_reg <= i_arr_rd_data;
      end
    end
  end
  assign o_dq = dq_reg;
  // Output enable gates drivers with no clock in the path
  assign o_dq_oe_n = !(drive_reg && !i_out_en_n);

  // Writes take the pin data in the same edge; a full FIFO drops them,
  // so the master must watch o_wr_ready, the array cannot stall it
  sram_wr_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_valid(is_wr),
    .o_ready(o_wr_ready),
    .i_data({eff_addr, lanes, i_dq}),
    .o_valid(o_arr_wr_valid),
    .i_ready(i_arr_wr_ready),
    .o_data(fifo_out)
  );
  assign o_arr_wr_addr = fifo_out[FIFO_W-1:LANES+DATA_W];
  assign o_arr_wr_lanes = fifo_out[LANES+DATA_W-1:DATA_W];
  assign o_arr_wr_data = fifo_out[DATA_W-1:0];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  property p_desel_quiet;
    (cyc == cyc_desel) |-> ##2 o_dq_oe_n;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("deselect drove pins");

  property p_enable_needed;
    (!i_ctrl_addr_load_n && !chip_en) |-> (cyc != cyc_begin);
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("begin while disabled");

  property p_proc_read;
    (chip_en && !i_proc_addr_load_n) |=> (o_arr_rd_en && o_arr_rd_addr == $past(i_addr));
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor strobe read wrong");

  property p_ctrl_write;
    (chip_en && i_proc_addr_load_n && !i_ctrl_addr_load_n && wr_qual) |=> !o_arr_rd_en;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("controller write read");

  property p_cont_step;
    (cyc == cyc_cont) |=> (cnt_reg == BURST_W'($past(cnt_reg) + BURST_STEP));
  endproperty
  a_cont_step: assert property (p_cont_step) else $error("continue did not step");

  property p_susp_hold;
    (cyc == cyc_susp) |=> ($stable(cnt_reg) && $stable(start_reg));
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("suspend moved address");

  property p_ignore_proc;
    (i_chip_sel_low_a && i_ctrl_addr_load_n) |-> (cyc == cyc_cont || cyc == cyc_susp);
  endproperty
  a_ignore_proc: assert property (p_ignore_proc) else $error("processor strobe obeyed");

  property p_oe_off;
    i_out_en_n |-> o_dq_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving with enable high");

  property p_oe_sched;
    !o_dq_oe_n |-> $past(is_rd, 2);
  endproperty
  a_oe_sched: assert property (p_oe_sched) else $error("driving without read");

  property p_write_quiet;
    is_wr |-> ##2 o_dq_oe_n;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("pins driven in write");

  property p_global_lanes;
    !i_all_bytes_write_n |-> (wr_qual && lanes == LANES_ALL);
  endproperty
  a_global_lanes: assert property (p_global_lanes) else $error("global write lanes");

  property p_wrap;
    (cyc == cyc_cont)[*4] |=> (cnt_reg == $past(cnt_reg, 4));
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst did not wrap");

  c_begin_read: cover property (cyc == cyc_begin && is_rd);
  c_begin_write: cover property (cyc == cyc_begin && is_wr);
  c_full_burst: cover property ((cyc == cyc_begin) ##1 (cyc == cyc_cont)[*3]);
  c_dummy_read: cover property (is_rd && i_out_en_n ##1 is_wr);
endmodule

// [dv/sram_array_model.sv]
/*
  Behavioural model of the storage array behind the cycle control block:
  answers read requests in the same cycle and takes FIFO writes per lane.
  Assumes addresses below 1024 and the same clock as the block.
*/
module sram_array_model (
  input wire logic i_clk_sys,
  input wire logic i_stall,
  input wire logic i_rd_en,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [sram_ctl_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [sram_ctl_pkg::LANES-1:0] i_wr_lanes,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] i_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ctl_pkg::*;
  logic [DATA_W-1:0] mem [0:1023];

  // Cleared store, so unwritten words read as zero
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = '0;
  end

  // Inverted outside a request so stale data is never trusted
  assign o_rd_data = i_rd_en ? mem[i_rd_addr[9:0]] : ~mem[i_rd_addr[9:0]];
  assign o_wr_ready = !i_stall;

  // Only enabled lanes change
  always @(posedge i_clk_sys) begin
    if (i_wr_valid && o_wr_ready) begin
      for (int l = 0; l < LANES; l++) begin
        if (i_wr_lanes[l]) begin
          mem[i_wr_addr[9:0]][l*LANE_W +: LANE_W] <= i_wr_data[l*LANE_W +: LANE_W];
        end
      end
    end
  end
endmodule

// [dv/sync_burst_sram_cycle_control_tb_top.sv]
/*
  Self-checking bench for the burst SRAM cycle control: drives pin cycles,
  records array reads and driven data, compares with expected sequences.
  Assumes the array model beside it and a 200 MHz clock.
*/
module sync_burst_sram_cycle_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ctl_pkg::*;
  // Control word: selA selH selB proc ctrl adv gw bw lanes[3:0]
  localparam logic [11:0] RDP = 12'h4ff, WRG = 12'h55f, BW0 = 12'h56e, RDC = 12'h57f;
  // Byte write of lanes 1 to 3 only, so every lane input toggles somewhere
  localparam logic [11:0] BW3 = 12'h561;
  localparam logic [11:0] BOTH = 12'h45f, CONT = 12'habf, SUSP = 12'hfff;
  localparam logic [11:0] DES = 12'hd7f, DS2 = 12'h0ff, DS3 = 12'h67f;
  logic clk, rst_b, sel_a, sel_h, sel_b, pn, cn, advn, gwn, bwn, lin_n, oe_n, stall;
  logic [3:0] ln;
  logic [ADDR_W-1:0] addr, rd_addr, wr_addr;
  logic [DATA_W-1:0] dq, o_dq, rd_data, wr_data;
  logic dq_oe_n, rd_en, wr_valid, wr_ready, fifo_rdy;
  logic [LANES-1:0] wr_lanes;
  logic [DATA_W-1:0] seen_rd[$], seen_dq[$], exp_rd[$], exp_dq[$];
  int n_errors, compares, pops;

  sram_cycle_ctl u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_chip_sel_low_a(sel_a),
    .i_chip_sel_high(sel_h), .i_chip_sel_low_b(sel_b), .i_proc_addr_load_n(pn),
    .i_ctrl_addr_load_n(cn), .i_burst_advance_n(advn), .i_all_bytes_write_n(gwn),
    .i_byte_write_gate_n(bwn), .i_lane0_write_n(ln[0]), .i_lane1_write_n(ln[1]),
    .i_lane2_write_n(ln[2]), .i_lane3_write_n(ln[3]), .i_linear_order_sel_n(lin_n),
    .i_out_en_n(oe_n), .i_addr(addr), .i_dq(dq), .o_dq(o_dq), .o_dq_oe_n(dq_oe_n),
    .o_arr_rd_en(rd_en), .o_arr_rd_addr(rd_addr), .i_arr_rd_data(rd_data),
    .o_arr_wr_valid(wr_valid), .i_arr_wr_ready(wr_ready), .o_arr_wr_addr(wr_addr),
    .o_arr_wr_lanes(wr_lanes), .o_arr_wr_data(wr_data), .o_wr_ready(fifo_rdy));
  sram_array_model u_arr (.i_clk_sys(clk), .i_stall(stall), .i_rd_en(rd_en),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
    .i_wr_addr(wr_addr), .i_wr_lanes(wr_lanes), .i_wr_data(wr_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Record array reads, driven data and array pops
  always @(posedge clk) begin
    if (rst_b === 1'b1) begin
      if (rd_en === 1'b1) seen_rd.push_back(DATA_W'(rd_addr));
      if (dq_oe_n === 1'b0) seen_dq.push_back(o_dq);
      if (wr_valid === 1'b1 && wr_ready === 1'b1) pops++;
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic step(input logic [11:0] c, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge clk);
    {sel_a, sel_h, sel_b, pn, cn, advn, gwn, bwn, ln} <= c;
    addr <= a;
    dq <= d;
  endtask

  task automatic idle(input int n);
    repeat (n) step(DES, '1, '1);
  endtask

  // Let the pipeline empty, then compare both recordings
  task automatic wrap();
    idle(5);
    chk("rd count", DATA_W'(exp_rd.size()), DATA_W'(seen_rd.size()));
    foreach (exp_rd[i]) if (i < seen_rd.size()) chk("rd addr", exp_rd[i], seen_rd[i]);
    chk("dq count", DATA_W'(exp_dq.size()), DATA_W'(seen_dq.size()));
    foreach (exp_dq[i]) if (i < seen_dq.size()) chk("dq data", exp_dq[i], seen_dq[i]);
    exp_rd.delete(); seen_rd.delete(); exp_dq.delete(); seen_dq.delete();
  endtask

  // Start a read burst and step it four times, ending back at the start
  task automatic burst(input logic [11:0] c, input logic [ADDR_W-1:0] base, input logic il);
    logic [1:0] o;
    lin_n <= il;
    step(c, base, '1);
    for (int k = 0; k < 5; k++) begin
      o = il ? (base[1:0] ^ k[1:0]) : (base[1:0] + k[1:0]);
      exp_rd.push_back(DATA_W'({base[ADDR_W-1:2], o}));
      exp_dq.push_back('0);
      if (k < 4) step(CONT, '1, '1);
    end
  endtask

  initial begin
    #50000;
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    {sel_a, sel_h, sel_b, pn, cn, advn, gwn, bwn, ln} = DES;
    addr = '0; dq = '0; lin_n = 1'b0; oe_n = 1'b0; stall = 1'b0;
    n_errors = 0; compares = 0; pops = 0;
    repeat (3) @(posedge clk);
    #1 chk("reset outs", DATA_W'(4'b1001), DATA_W'({dq_oe_n, rd_en, wr_valid, fifo_rdy}));
    @(posedge clk);
    rst_b <= 1'b1;
    // Full and byte writes, then reads by processor strobe and both strobes
    step(WRG, 20'h00104, 36'h9_1234_5678);
    step(WRG, 20'h00105, 36'h8_7654_3210);
    step(BW0, 20'h00105, 36'h0_0000_01a5);
    step(BW3, 20'h00106, 36'hf_ffff_ffff);
    idle(6);
    step(RDP, 20'h00104, '1);
    step(BOTH, 20'h00105, '1);
    step(RDP, 20'h00106, '1);
    exp_rd = '{36'h104, 36'h105, 36'h106};
    exp_dq = '{36'h9_1234_5678, 36'h8_7654_33a5, 36'hf_ffff_fe00};
    wrap();
    burst(RDC, 20'h00201, 1'b0);
    step(SUSP, '1, '1);
    exp_rd.push_back(36'h201);
    exp_dq.push_back('0);
    wrap();
    burst(RDP, 20'h00302, 1'b1);
    wrap();
    step(DES, 20'h00111, '1);
    step(DS2, 20'h00112, '1);
    step(DS3, 20'h00113, '1);
    wrap();
    // Dummy reads straight into a write, no deselect between
    oe_n <= 1'b1;
    step(RDP, 20'h00400, '1);
    step(CONT, '1, '1);
    step(WRG, 20'h00410, 36'h5_a5a5_a5a5);
    exp_rd = '{36'h400, 36'h401};
    idle(4);
    oe_n <= 1'b0;
    step(RDP, 20'h00410, '1);
    exp_rd.push_back(36'h410);
    exp_dq.push_back(36'h5_a5a5_a5a5);
    wrap();
    // Output enable pulled high in mid-cycle while data stands
    step(RDP, 20'h00104, '1);
    step(DES, '1, '1);
    @(posedge clk);
    #1 chk("drive on", '0, DATA_W'(dq_oe_n));
    oe_n = 1'b1;
    #0.5 chk("drive off", DATA_W'(1'b1), DATA_W'(dq_oe_n));
    @(posedge clk);
    oe_n <= 1'b0;
    exp_rd.push_back(36'h104);
    wrap();
    // Fill the write FIFO with the array stalled, then drain it
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) step(WRG, 20'h00500 + 20'(i), DATA_W'(32'hc000 + i));
    idle(3);
    chk("fifo ready full", '0, DATA_W'(fifo_rdy));
    pops = 0;
    stall <= 1'b0;
    idle(25);
    chk("fifo pops", DATA_W'(16), DATA_W'(pops));
    chk("fifo ready empty", DATA_W'(1'b1), DATA_W'(fifo_rdy));
    step(RDP, 20'h0050f, '1);
    exp_rd.push_back(36'h50f);
    exp_dq.push_back(36'hc00f);
    wrap();
    tally_and_finish();
  end
endmodule
